// File: pkg/srxeof_pkg.sv
package srxeof_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CMD   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_IP    = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_MASK  = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_FSTAT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 4'h5;

    // Control register fields
    localparam int unsigned CTRL_FIFO_EN  = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam int unsigned CTRL_RX_SRC   = 3;
    localparam int unsigned CTRL_TX_SRC   = 4;
    localparam int unsigned CTRL_DIV4     = 5;
    localparam int unsigned CTRL_RX_EN    = 6;
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

    // Command register bits
    localparam int unsigned CMD_RHIS    = 0;
    localparam int unsigned CMD_ERR_RST = 1;
    localparam int unsigned CMD_ACK     = 2;

    // Pending flags, mask uses the same layout
    localparam int unsigned IP_W    = 3;
    localparam int unsigned IP_RCA  = 0;
    localparam int unsigned IP_SPEC = 1;
    localparam int unsigned IP_EXT  = 2;
    localparam logic [IP_W-1:0] IP_RST   = 3'h0;
    localparam logic [IP_W-1:0] MASK_RST = 3'h0;

    // In-service flags
    localparam int unsigned IUS_EXT = 0;
    localparam int unsigned IUS_RX  = 1;

    // Frame status register fields
    localparam int unsigned FSTAT_OVF   = 7;
    localparam int unsigned FSTAT_VALID = 6;
    localparam logic [3:0]  FRAME_MAX   = 4'ha;

    // Data FIFO geometry
    localparam int unsigned DFIFO_DEPTH = 4;
    localparam int unsigned DFIFO_AW    = 2;
    localparam logic [2:0]  DFIFO_FULL  = 3'h4;

    // Bit rate limit: one bit per four peripheral clocks at most
    localparam logic [2:0] MIN_BIT_CYC = 3'h4;

    localparam logic [7:0] FLAG_BYTE = 8'h7e;

    typedef enum logic [1:0] {
        RXI_OFF,
        RXI_FIRST_SPEC,
        RXI_ALL,
        RXI_SPEC_ONLY
    } srxeof_rxi_e;

    typedef enum logic {
        DF_HUNT,
        DF_FRAME
    } srxeof_df_e;

endpackage

// File: pkg/srxeof_rx_if.sv
`timescale 1ns/1ps
interface srxeof_rx_if;
    logic       rx_tick;
    logic       rx_bit;
    logic [7:0] data;
    logic       data_vld;
    logic       data_eof;
    logic       frame_end;

    modport src (output rx_tick, rx_bit);
    modport dfr (input rx_tick, rx_bit, output data, data_vld, data_eof, frame_end);
    modport snk (input data, data_vld, data_eof, frame_end);
endinterface

// File: src/srxeof_clk_sel.sv
`timescale 1ns/1ps
module srxeof_clk_sel (
    input  wire logic  clk,          // Peripheral clock
    input  wire logic  rst_n,        // Synchronised reset
    input  wire logic  ce,           // Clock enable
    input  wire logic  clock_pin_a,  // Line clock pin a
    input  wire logic  clock_pin_b,  // Line clock pin b
    input  wire logic  rx_data_pin,  // Serial receive data
    input  wire logic  rx_src,       // Receive clock source, 1 selects pin b
    input  wire logic  tx_src,       // Transmit clock source, 1 selects pin b
    input  wire logic  div4,         // Internal divide-by-four bit clock
    srxeof_rx_if.src   lnk,          // Bit ticks toward the deframer
    output logic       tx_clk_lvl    // Filtered transmit clock level
);
    import srxeof_pkg::*;

    logic [2:0] s1_q, s2_q, s3_q, lvl_q;
    logic [2:0] gap_q;
    wire  [2:0] agree  = ~(s2_q ^ s3_q);
    wire  [2:0] lvl_d  = (agree & s3_q) | (~agree & lvl_q);
    wire        rx_now = rx_src ? lvl_q[1] : lvl_q[0];
    wire        rx_nxt = rx_src ? lvl_d[1] : lvl_d[0];
    // In divide-by-four the pin clock is not used, so no synchroniser delay applies
    wire        tick   = (gap_q == 3'h0) && (div4 || (rx_nxt && !rx_now));
    wire  [2:0] gap_d  = tick ? 3'(MIN_BIT_CYC - 3'h1) : ((gap_q != 3'h0) ? 3'(gap_q - 3'h1) : 3'h0);

    assign tx_clk_lvl = tx_src ? lvl_q[1] : lvl_q[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q        <= 3'h0;
            s2_q        <= 3'h0;
            s3_q        <= 3'h0;
            lvl_q       <= 3'h0;
            gap_q       <= 3'h0;
            lnk.rx_tick <= 1'b0;
            lnk.rx_bit  <= 1'b0;
        end else if (ce) begin
            s1_q        <= {rx_data_pin, clock_pin_b, clock_pin_a};
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            lvl_q       <= lvl_d;
            gap_q       <= gap_d;
            lnk.rx_tick <= tick;
            lnk.rx_bit  <= lvl_d[2];
        end
    end

    rate_gap_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        lnk.rx_tick |=> !lnk.rx_tick [*3]
    ) else $error("bit ticks closer than four clocks");

    div4_tick_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        (div4 && lnk.rx_tick) ##1 div4 [*3] |=> lnk.rx_tick
    ) else $error("divide-by-four tick missing");

endmodule // srxeof_clk_sel

// File: src/srxeof_deframer.sv
`timescale 1ns/1ps
module srxeof_deframer (
    input  wire logic  clk,    // Peripheral clock
    input  wire logic  rst_n,  // Synchronised reset
    input  wire logic  ce,     // Clock enable
    input  wire logic  rx_en,  // Receiver enable
    srxeof_rx_if.dfr   lnk     // Bits in, bytes out
);
    import srxeof_pkg::*;

    srxeof_df_e state_q;
    logic [7:0] sr_q, pend_q;
    logic [2:0] bitcnt_q;
    logic       pend_v_q;
    wire  [7:0] sr_nx   = {lnk.rx_bit, sr_q[7:1]};
    wire        is_flag = (sr_nx == FLAG_BYTE);

    // One byte is held back so that the closing flag can tag it as end of frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= DF_HUNT;
            sr_q          <= 8'h00;
            pend_q        <= 8'h00;
            bitcnt_q      <= 3'h0;
            pend_v_q      <= 1'b0;
            lnk.data      <= 8'h00;
            lnk.data_vld  <= 1'b0;
            lnk.data_eof  <= 1'b0;
            lnk.frame_end <= 1'b0;
        end else if (ce) begin
            lnk.data_vld  <= 1'b0;
            lnk.data_eof  <= 1'b0;
            lnk.frame_end <= 1'b0;
            if (!rx_en) begin
                state_q  <= DF_HUNT;
                pend_v_q <= 1'b0;
            end else if (lnk.rx_tick) begin
                sr_q <= sr_nx;
                case (state_q)
                    DF_HUNT: begin
                        bitcnt_q <= 3'h0;
                        if (is_flag) begin
                            state_q <= DF_FRAME;
                        end
                    end
                    DF_FRAME: begin
                        if (is_flag) begin
                            bitcnt_q <= 3'h0;
                            if (pend_v_q) begin
                                lnk.data      <= pend_q;
                                lnk.data_vld  <= 1'b1;
                                lnk.data_eof  <= 1'b1;
                                lnk.frame_end <= 1'b1;
                                pend_v_q      <= 1'b0;
                            end
                        end else begin
                            bitcnt_q <= 3'(bitcnt_q + 3'h1);
                            if (bitcnt_q == 3'h7) begin
                                lnk.data     <= pend_q;
                                lnk.data_vld <= pend_v_q;
                                pend_q       <= sr_nx;
                                pend_v_q     <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_q <= DF_HUNT;
                    end
                endcase
            end
        end
    end

endmodule // srxeof_deframer

// File: src/srxeof_top.sv
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module srxeof_top (
    input  wire logic                          clk,          // Peripheral clock, 200 MHz
    input  wire logic                          nrst,         // Asynchronous reset, active low
    input  wire logic                          ce,           // Clock enable, freezes all state but the reset synchroniser when low
    input  wire logic [srxeof_pkg::ADDR_W-1:0] reg_addr,     // Register address
    input  wire logic [srxeof_pkg::DATA_W-1:0] reg_wdata,    // Register write data
    input  wire logic                          reg_wr,       // Register write strobe
    input  wire logic                          reg_rd,       // Register read strobe
    output logic      [srxeof_pkg::DATA_W-1:0] reg_rdata,    // Read data, cycle after the strobe
    input  wire logic                          clock_pin_a,  // Line clock pin a
    input  wire logic                          clock_pin_b,  // Line clock pin b
    input  wire logic                          rx_data_pin,  // Serial receive data pin
    input  wire logic                          ext_status_evt, // External status event pulse
    input  wire logic                          dma_rd,       // DMA read strobe
    output logic      [7:0]                    dma_data,     // Byte read by DMA
    output logic                               dma_eof,      // Byte read was end of frame
    output logic                               dma_ready,    // FIFO holds a readable byte
    output logic                               irq,          // Level interrupt, active high
    output logic                               int_od_o,     // Open-drain interrupt pin value
    output logic                               int_od_oe     // Open-drain pin driven low while high
);
    import srxeof_pkg::*;

    function automatic logic [DFIFO_AW-1:0] ptr_inc(input logic [DFIFO_AW-1:0] p);
        ptr_inc = DFIFO_AW'(p + 1'b1);
    endfunction

    logic [1:0] rst_sync_q;
    wire        rst_n = rst_sync_q[1];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    srxeof_rx_if lnk ();
    logic tx_lvl;
    logic [DATA_W-1:0] ctrl_q;

    srxeof_clk_sel u_clk_sel (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .clock_pin_a (clock_pin_a),
        .clock_pin_b (clock_pin_b),
        .rx_data_pin (rx_data_pin),
        .rx_src      (ctrl_q[CTRL_RX_SRC]),
        .tx_src      (ctrl_q[CTRL_TX_SRC]),
        .div4        (ctrl_q[CTRL_DIV4]),
        .lnk         (lnk.src),
        .tx_clk_lvl  (tx_lvl)
    );

    srxeof_deframer u_deframer (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .rx_en (ctrl_q[CTRL_RX_EN]),
        .lnk   (lnk.dfr)
    );

    logic [IP_W-1:0]     ip_q, mask_q;
    logic [1:0]          ius_q;
    logic                lock_q, first_q, fovf_q;
    logic [3:0]          fcnt_q;
    logic [8:0]          mem_q [DFIFO_DEPTH];
    logic [DFIFO_AW-1:0] wp_q, rp_q;
    logic [2:0]          lvl_q;

    // Register decode
    wire wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_cmd   = reg_wr && (reg_addr == ADDR_CMD);
    wire wr_ip    = reg_wr && (reg_addr == ADDR_IP);
    wire wr_mask  = reg_wr && (reg_addr == ADDR_MASK);
    wire rd_fstat = reg_rd && (reg_addr == ADDR_FSTAT);
    wire rhis     = wr_cmd && reg_wdata[CMD_RHIS];
    wire errr     = wr_cmd && reg_wdata[CMD_ERR_RST];
    wire ack      = wr_cmd && reg_wdata[CMD_ACK];

    // Mode decode
    wire         fifo_en    = ctrl_q[CTRL_FIFO_EN];
    srxeof_rxi_e rxi_mode;
    assign rxi_mode = srxeof_rxi_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
    wire         spec_only  = fifo_en && (rxi_mode == RXI_SPEC_ONLY);
    wire         first_mode = (rxi_mode == RXI_FIRST_SPEC);
    wire         rx_irq_on  = (rxi_mode != RXI_OFF);

    // Data FIFO
    wire       full     = (lvl_q == DFIFO_FULL);
    wire       push_ok  = lnk.data_vld && !full;
    wire       overrun  = lnk.data_vld && full;
    wire       pop      = dma_rd && (lvl_q != 3'h0) && !lock_q;
    wire [8:0] head     = mem_q[rp_q];
    wire       eof_read = pop && head[8];
    wire [2:0] lvl_d    = 3'(lvl_q + {2'b00, push_ok} - {2'b00, pop});

    // Pending flag events; a set always wins over a clear in the same cycle
    wire set_rca  = (eof_read && spec_only)
                 || (push_ok && ((rxi_mode == RXI_ALL) || (first_mode && first_q)));
    wire set_spec = rx_irq_on && ((eof_read && !spec_only) || overrun);
    wire [IP_W-1:0] ev_set  = {ext_status_evt, set_spec, set_rca};
    wire [IP_W-1:0] w1c     = wr_ip ? reg_wdata[IP_W-1:0] : IP_RST;
    // A locked special condition ignores write-one-to-clear and waits for error reset
    wire [IP_W-1:0] w1c_eff = w1c & ~({IP_W{lock_q}} & (IP_W'(1) << IP_SPEC));
    wire [IP_W-1:0] hw_clr  = ({IP_W{rhis && spec_only}} & (IP_W'(1) << IP_RCA))
                            | ({IP_W{errr}} & (IP_W'(1) << IP_SPEC));
    wire [IP_W-1:0] ip_d    = (ip_q & ~(w1c_eff | hw_clr)) | ev_set;
    wire [IP_W-1:0] mask_d  = wr_mask ? reg_wdata[IP_W-1:0] : mask_q;
    wire            int_d   = |(ip_d & mask_d);

    wire lock_d = !spec_only && ((eof_read && rx_irq_on) || (lock_q && !errr));

    // In-service flags: receive outranks external status
    wire       rx_pend = ip_q[IP_RCA] || ip_q[IP_SPEC];
    wire [1:0] ius_set = !ack ? 2'b00 : rx_pend ? 2'b10 : ip_q[IP_EXT] ? 2'b01 : 2'b00;
    wire [1:0] ius_clr = !rhis ? 2'b00 : ius_q[IUS_RX] ? 2'b10 : 2'b01;
    wire [1:0] ius_d   = (ius_q & ~ius_clr) | ius_set;

    // Frame counter; overflow clears on read only outside anti-lock
    wire       fend   = lnk.frame_end && fifo_en;
    wire       fpop   = rd_fstat && (fcnt_q != 4'h0);
    wire       fovf_d = fifo_en && ((fend && (fcnt_q == FRAME_MAX)) || (fovf_q && !(rd_fstat && !spec_only)));
    wire       finc   = fend && (fcnt_q != FRAME_MAX);
    wire [3:0] fcnt_d = !fifo_en ? 4'h0 : 4'(fcnt_q + {3'h0, finc} - {3'h0, fpop});

    wire [7:0] fstat_val = {fovf_q, (fcnt_q != 4'h0), 2'b00, fcnt_q};
    wire [7:0] stat_val  = {1'b0, lock_q, ius_q, tx_lvl, lvl_q};
    wire [7:0] rd_mux    = (reg_addr == ADDR_CTRL)  ? ctrl_q
                         : (reg_addr == ADDR_IP)    ? {5'h00, ip_q}
                         : (reg_addr == ADDR_MASK)  ? {5'h00, mask_q}
                         : (reg_addr == ADDR_FSTAT) ? fstat_val
                         : (reg_addr == ADDR_STAT)  ? stat_val
                         : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            mask_q <= MASK_RST;
            ip_q   <= IP_RST;
            ius_q  <= 2'b00;
            lock_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= wr_ctrl ? reg_wdata : ctrl_q;
            mask_q <= mask_d;
            ip_q   <= ip_d;
            ius_q  <= ius_d;
            lock_q <= lock_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b1;
            fcnt_q  <= 4'h0;
            fovf_q  <= 1'b0;
            wp_q    <= '0;
            rp_q    <= '0;
            lvl_q   <= 3'h0;
        end else if (ce) begin
            first_q <= lnk.frame_end || (first_q && !push_ok);
            fcnt_q  <= fcnt_d;
            fovf_q  <= fovf_d;
            wp_q    <= push_ok ? ptr_inc(wp_q) : wp_q;
            rp_q    <= pop ? ptr_inc(rp_q) : rp_q;
            lvl_q   <= lvl_d;
        end
    end

    // Storage has no reset; contents are only read behind the level count
    always_ff @(posedge clk) begin
        if (ce && push_ok) begin
            mem_q[wp_q] <= {lnk.data_eof, lnk.data};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            dma_data  <= 8'h00;
            dma_eof   <= 1'b0;
            dma_ready <= 1'b0;
            irq       <= 1'b0;
            int_od_o  <= 1'b0;
            int_od_oe <= 1'b0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            dma_data  <= pop ? head[7:0] : dma_data;
            dma_eof   <= pop ? head[8] : dma_eof;
            dma_ready <= (lvl_d != 3'h0) && !lock_d;
            irq       <= int_d;
            // Open-drain pin only ever pulls low; the enable carries the interrupt
            int_od_o  <= 1'b0;
            int_od_oe <= int_d;
        end
    end

    eof_rca_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        eof_read && spec_only && !overrun |=> ip_q[IP_RCA] && (!ip_q[IP_SPEC] || $past(ip_q[IP_SPEC]))
    ) else $error("end of frame did not raise character-available");

    no_lock_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        spec_only |=> !lock_q
    ) else $error("data FIFO locked in special-only mode");

    eof_pin_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        eof_read && spec_only && mask_d[IP_RCA] |=> int_od_oe && irq && (int_od_o == 1'b0)
    ) else $error("interrupt pin not driven after end-of-frame read");

    rhis_rca_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        rhis && spec_only && !set_rca |=> !ip_q[IP_RCA]
    ) else $error("reset-highest left character-available pending");

    lock_eof_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        first_mode && eof_read ##1 (!errr && first_mode) [*2] |-> lock_q && ip_q[IP_SPEC] && !dma_ready
    ) else $error("FIFO not locked after end of frame");

    rhis_keep_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        first_mode && rhis && !errr |=> (ip_q & $past(ip_q)) == $past(ip_q)
    ) else $error("reset-highest changed a pending flag");

    frame_valid_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        rd_fstat |=> reg_rdata[FSTAT_VALID] == ($past(fcnt_q) != 4'h0)
    ) else $error("frame valid bit wrong");

    ius_clear_a: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        rhis && !ack && ius_q[IUS_RX] |=> !ius_q[IUS_RX] && (ius_q[IUS_EXT] == $past(ius_q[IUS_EXT]))
    ) else $error("reset-highest cleared the wrong in-service flag");

endmodule // srxeof_top

// File: sim/srxeof_dma_model.sv
`timescale 1ns/1ps
module srxeof_dma_model (
    input  wire logic       clk,        // Peripheral clock
    input  wire logic       rst_n,      // Reset, active low
    input  wire logic       hold,       // Stall reading while high
    input  wire logic       dma_ready,  // Device holds a byte
    input  wire logic [7:0] dma_data,   // Byte returned
    input  wire logic       dma_eof,    // Byte closed a frame
    output logic            dma_rd,     // Read strobe
    output logic      [7:0] last_q,     // Last byte taken
    output logic            eof_q,      // Last byte closed a frame
    output logic      [7:0] pops_q      // Bytes taken
);
    logic took_q;

    // A strobe at most every third cycle, since ready lags a pop by one edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_rd <= 1'b0;
            took_q <= 1'b0;
            last_q <= 8'h00;
            eof_q  <= 1'b0;
            pops_q <= 8'h00;
        end else begin
            dma_rd <= !hold && dma_ready && !dma_rd && !took_q;
            took_q <= dma_rd;
            if (took_q) begin
                last_q <= dma_data;
                eof_q  <= dma_eof;
                pops_q <= pops_q + 8'h01;
            end
        end
    end
endmodule // srxeof_dma_model

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import srxeof_pkg::*;

    localparam int LIMIT = 20000;
    localparam logic [3:0] RST_ADDR [6] = '{ADDR_CTRL, ADDR_IP, ADDR_MASK, ADDR_FSTAT, ADDR_STAT, 4'hf};

    logic       clk = 1'b0;
    logic       nrst;
    logic       ce;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       clock_pin_a;
    logic       clock_pin_b;
    logic       rx_data_pin;
    logic       ext_status_evt;
    logic       dma_rd;
    logic [7:0] dma_data;
    logic       dma_eof;
    logic       dma_ready;
    logic       irq;
    logic       int_od_o;
    logic       int_od_oe;
    logic       hold;
    logic [7:0] last_q;
    logic       eof_q;
    logic [7:0] pops_q;
    logic [7:0] d;
    int         checked = 0;
    int         bad_count = 0;
    int         cyc = 0;

    always #2.5 clk = ~clk;

    srxeof_top dut_u (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_pin_a(clock_pin_a),
        .clock_pin_b(clock_pin_b), .rx_data_pin(rx_data_pin), .ext_status_evt(ext_status_evt),
        .dma_rd(dma_rd), .dma_data(dma_data), .dma_eof(dma_eof), .dma_ready(dma_ready), .irq(irq),
        .int_od_o(int_od_o), .int_od_oe(int_od_oe));

    srxeof_dma_model dma_u (.clk(clk), .rst_n(nrst), .hold(hold), .dma_ready(dma_ready),
        .dma_data(dma_data), .dma_eof(dma_eof), .dma_rd(dma_rd), .last_q(last_q), .eof_q(eof_q),
        .pops_q(pops_q));

    task automatic finish_test();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    // Data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
        @(posedge clk);
    endtask

    task automatic pulse_ext();
        ext_status_evt <= 1'b1;
        @(posedge clk);
        ext_status_evt <= 1'b0;
        @(posedge clk);
    endtask

    // LSB first, data moved on the falling line clock edge, 125 ns period
    task automatic send_byte(input logic [7:0] b, input logic use_b);
        for (int i = 0; i < 8; i++) begin
            rx_data_pin <= b[i];
            repeat (13) @(posedge clk);
            {clock_pin_b, clock_pin_a} <= use_b ? 2'b10 : 2'b01;
            repeat (12) @(posedge clk);
            {clock_pin_b, clock_pin_a} <= 2'b00;
        end
    endtask

    // Line clock stands still between frames; data line toggles so a stale bit is never seen
    task automatic send_frame(input logic [7:0] b0, input logic [7:0] b1, input logic use_b);
        send_byte(FLAG_BYTE, use_b);
        send_byte(b0, use_b);
        send_byte(b1, use_b);
        send_byte(FLAG_BYTE, use_b);
        rx_data_pin <= ~rx_data_pin;
        repeat (20) @(posedge clk);
    endtask

    task automatic drain();
        hold <= 1'b0;
        repeat (12) @(posedge clk);
        hold <= 1'b1;
    endtask

    initial begin
        {nrst, reg_addr, reg_wdata, reg_wr, reg_rd, ext_status_evt} = '0;
        {clock_pin_a, clock_pin_b, rx_data_pin} = 3'b000;
        ce   = 1'b1;
        hold = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(RST_ADDR[i], d);
            check(d, 8'h00);
        end
        check({6'h0, int_od_oe, int_od_o}, 8'h00);
        $display("test reset values done");

        ce <= 1'b0;
        wr(ADDR_MASK, 8'h07);
        ce <= 1'b1;
        rd(ADDR_MASK, d);
        check(d, 8'h00);
        wr(ADDR_CTRL, 8'h30);
        clock_pin_b <= 1'b1;
        repeat (16) @(posedge clk);
        rd(ADDR_STAT, d);
        check(d & 8'h08, 8'h08);
        clock_pin_b <= 1'b0;
        $display("test enable and clock selection done");

        wr(ADDR_MASK, 8'h07);
        wr(ADDR_CTRL, 8'h47);
        send_frame(8'ha5, 8'h3c, 1'b0);
        rd(ADDR_STAT, d);
        check(d & 8'h47, 8'h02);
        rd(ADDR_IP, d);
        check(d, 8'h00);
        drain();
        check(pops_q, 8'h02);
        check({last_q[7:1], eof_q}, 8'h3d);
        rd(ADDR_IP, d);
        check(d, 8'h01);
        check({6'h0, int_od_oe, int_od_o}, 8'h02);
        check({7'h0, irq}, 8'h01);
        rd(ADDR_STAT, d);
        check(d & 8'h47, 8'h00);
        $display("test end of frame interrupt done");

        pulse_ext();
        rd(ADDR_IP, d);
        check(d, 8'h05);
        wr(ADDR_CMD, 8'h01 << CMD_ACK);
        rd(ADDR_STAT, d);
        check(d & 8'h30, 8'h20);
        wr(ADDR_CMD, 8'h01 << CMD_RHIS);
        rd(ADDR_IP, d);
        check(d, 8'h04);
        rd(ADDR_STAT, d);
        check(d & 8'h30, 8'h00);
        rd(ADDR_FSTAT, d);
        check(d, 8'h41);
        rd(ADDR_FSTAT, d);
        check(d, 8'h00);
        wr(ADDR_IP, 8'h04);
        wr(ADDR_MASK, 8'h03);
        pulse_ext();
        rd(ADDR_IP, d);
        check(d, 8'h04);
        check({7'h0, irq}, 8'h00);
        wr(ADDR_IP, 8'h04);
        $display("test reset highest in service done");

        pulse_ext();
        wr(ADDR_CMD, 8'h01 << CMD_ACK);
        wr(ADDR_CTRL, 8'h4b);
        send_frame(8'h81, 8'h18, 1'b1);
        drain();
        check(pops_q, 8'h04);
        check({last_q[7:1], eof_q}, 8'h19);
        rd(ADDR_IP, d);
        check(d & 8'h02, 8'h02);
        wr(ADDR_CMD, 8'h01 << CMD_ACK);
        rd(ADDR_STAT, d);
        check(d & 8'h70, 8'h70);
        wr(ADDR_CMD, 8'h01 << CMD_RHIS);
        rd(ADDR_IP, d);
        check(d & 8'h02, 8'h02);
        rd(ADDR_STAT, d);
        check(d & 8'h30, 8'h10);
        wr(ADDR_CMD, 8'h01 << CMD_RHIS);
        wr(ADDR_IP, 8'h02);
        rd(ADDR_IP, d);
        check(d & 8'h02, 8'h02);
        wr(ADDR_CMD, 8'h01 << CMD_ERR_RST);
        rd(ADDR_STAT, d);
        check(d & 8'h70, 8'h00);
        wr(ADDR_IP, 8'h07);
        rd(ADDR_IP, d);
        check(d, 8'h00);
        check({7'h0, irq}, 8'h00);
        $display("test locking mode done");
        finish_test();
    end
endmodule // tb
